// ### dv/sfspd_host.sv
// host model: chip select, link clock and io lines for one frame
// assumes the bench resolves the io wires from the device enables
`timescale 1ns/1ps
module sfspd_host (
    input wire logic clk,
    input wire logic io0_w,
    input wire logic io1_w,
    output logic cs_n,
    output logic sck,
    output logic io0,
    output logic io1
);
    // idle: deselected, link clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io0 = 1'b0;
        io1 = 1'b0;
    end
    // one frame of nclk clocks, mode 0; rx keeps the last 16 bits seen
    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input bit dual,
                        input int nclk, output logic [15:0] rx);
        int k;
        logic b0;
        logic b1;
        rx = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < nclk; i++) begin
            k = 2 * (i - 8);
            b0 = ~io0; // released lines keep toggling
            b1 = ~io1;
            if (i < 8) begin
                b0 = op[7-i];
            end else if (dual && i < 20) begin
                b1 = a[23-k];
                b0 = a[22-k];
            end else if (dual && i < 24) begin
                b1 = (i < 22);
                b0 = (i < 22);
            end else if (!dual && i < 32) begin
                b0 = a[31-i];
            end
            @(posedge clk);
            io0 <= b0;
            io1 <= b1;
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            rx = dual ? {rx[13:0], io1_w, io0_w} : {rx[14:0], io1_w};
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ### dv/testbench.sv
// self-checking bench for the suspend, power-down and id-read block
// assumes the host model sfspd_host and the design package
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_start = 1'b0;
    logic op_done = 1'b0;
    sfspd_pkg::sfspd_kind_type op_kind = sfspd_pkg::SFSPD_KIND_SECTOR_ERASE;
    logic cs_n, sck, h_io0, h_io1, io0_w, io1_w, o0, e0, o1, e1;
    logic array_run, busy, suspend_flag, powered_down, e_ok, p_ok, w_ok;
    logic [15:0] rx;
    logic [7:0] m = sfspd_pkg::MANUFACTURER_ID;
    logic [7:0] d = sfspd_pkg::DEVICE_ID;
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    always #4 clk = ~clk;
    // io wires: device drive wins while its enable is high
    assign io0_w = e0 ? o0 : h_io0;
    assign io1_w = e1 ? o1 : h_io1;
    sfspd_core i_sfspd_core (.clk(clk), .rst(rst), .spi_cs_n(cs_n), .spi_sck(sck),
        .spi_io0_in(io0_w), .spi_io1_in(io1_w), .spi_io0_out(o0), .spi_io0_oe(e0),
        .spi_io1_out(o1), .spi_io1_oe(e1), .op_start(op_start), .op_kind(op_kind),
        .op_done(op_done), .array_run(array_run), .busy(busy), .suspend_flag(suspend_flag),
        .powered_down(powered_down), .erase_permit(e_ok), .program_permit(p_ok),
        .status_write_permit(w_ok));
    sfspd_host i_sfspd_host (.clk(clk), .io0_w(io0_w), .io1_w(io1_w), .cs_n(cs_n),
        .sck(sck), .io0(h_io0), .io1(h_io1));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    // one start or done pulse from the array engine
    task automatic eng(input logic start, input sfspd_pkg::sfspd_kind_type kind);
        @(posedge clk);
        op_start <= start;
        op_done <= ~start;
        op_kind <= kind;
        @(posedge clk);
        op_start <= 1'b0;
        op_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit dl, input int c);
        i_sfspd_host.xfer(op, a, dl, c, rx);
    endtask
    // bounded wait for busy (0) or powered_down (1) to fall
    task automatic wait_low(input logic pd, input int lim);
        for (n = 0; n < lim && (pd ? powered_down : busy) !== 1'b0; n++) @(posedge clk);
        if (n >= lim) begin
            chk(1'b0, "wait ran out");
            final_report();
        end
    endtask
    task automatic t_suspend();
        eng(1'b1, sfspd_pkg::SFSPD_KIND_SECTOR_ERASE);
        chk(busy === 1'b1 && array_run === 1'b1, "busy erasing");
        cmd(sfspd_pkg::OP_SUSPEND, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b1 && busy === 1'b1 && array_run === 1'b0, "suspend");
        chk(e_ok === 1'b0 && w_ok === 1'b0 && p_ok === 1'b1, "erase permits");
        wait_low(1'b0, 2500);
        cmd(sfspd_pkg::OP_SUSPEND, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b1 && busy === 1'b0, "second suspend");
        cmd(sfspd_pkg::OP_RESUME, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b0 && busy === 1'b1 && array_run === 1'b1, "resume");
        cmd(sfspd_pkg::OP_RESUME, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b0 && busy === 1'b1, "resume while busy");
        repeat (2500) @(posedge clk);
        cmd(sfspd_pkg::OP_SUSPEND, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b1, "suspend after resume");
        wait_low(1'b0, 2500);
        cmd(sfspd_pkg::OP_RESUME, 24'h000000, 1'b0, 8);
        eng(1'b0, sfspd_pkg::SFSPD_KIND_SECTOR_ERASE);
        chk(busy === 1'b0 && e_ok === 1'b1, "erase done");
        cmd(sfspd_pkg::OP_RESUME, 24'h000000, 1'b0, 8);
        chk(busy === 1'b0 && array_run === 1'b0, "resume unsuspended");
    endtask
    task automatic t_chip_prog();
        eng(1'b1, sfspd_pkg::SFSPD_KIND_CHIP_ERASE);
        cmd(sfspd_pkg::OP_SUSPEND, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b0 && busy === 1'b1, "chip erase");
        cmd(sfspd_pkg::OP_RELEASE_ID, 24'h000000, 1'b0, 48);
        chk(busy === 1'b1 && rx !== {d, d}, "id while busy");
        eng(1'b0, sfspd_pkg::SFSPD_KIND_CHIP_ERASE);
        eng(1'b1, sfspd_pkg::SFSPD_KIND_PAGE_PROGRAM);
        cmd(sfspd_pkg::OP_SUSPEND, 24'h000000, 1'b0, 8);
        chk(suspend_flag === 1'b1 && p_ok === 1'b0 && w_ok === 1'b0, "program");
        wait_low(1'b0, 2500);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(suspend_flag === 1'b0 && p_ok === 1'b1, "power loss");
        cmd(sfspd_pkg::OP_RESUME, 24'h000000, 1'b0, 8);
        chk(busy === 1'b0 && array_run === 1'b0, "resume after loss");
    endtask
    task automatic t_ids();
        cmd(sfspd_pkg::OP_RELEASE_ID, 24'h000000, 1'b0, 48);
        chk(rx === {d, d}, "device id");
        cmd(sfspd_pkg::OP_MFR_DEV_ID, 24'h000000, 1'b0, 48);
        chk(rx === {m, d}, "ids addr 0");
        cmd(sfspd_pkg::OP_MFR_DEV_ID, 24'h000001, 1'b0, 56);
        chk(rx === {m, d}, "ids addr 1");
        cmd(sfspd_pkg::OP_MFR_DEV_ID_DUAL, 24'h000000, 1'b1, 32);
        chk(rx === {m, d}, "dual ids");
    endtask
    task automatic t_sleep();
        cmd(sfspd_pkg::OP_POWERDOWN, 24'h000000, 1'b0, 9);
        chk(powered_down === 1'b0, "long frame");
        cmd(sfspd_pkg::OP_POWERDOWN, 24'h000000, 1'b0, 8);
        chk(powered_down === 1'b1, "power-down");
        repeat (400) @(posedge clk);
        cmd(sfspd_pkg::OP_MFR_DEV_ID, 24'h000000, 1'b0, 48);
        chk(rx !== {m, d} && powered_down === 1'b1, "asleep read");
        cmd(sfspd_pkg::OP_RELEASE_ID, 24'h000000, 1'b0, 8);
        wait_low(1'b1, 375);
        cmd(sfspd_pkg::OP_POWERDOWN, 24'h000000, 1'b0, 8);
        repeat (400) @(posedge clk);
        cmd(sfspd_pkg::OP_RELEASE_ID, 24'h000000, 1'b0, 48);
        wait_low(1'b1, 225);
        cmd(sfspd_pkg::OP_RELEASE_ID, 24'h000000, 1'b0, 48);
        chk(rx === {d, d}, "id after wake");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(busy === 1'b0 && suspend_flag === 1'b0 && powered_down === 1'b0, "reset");
        t_suspend();
        t_chip_prog();
        t_ids();
        t_sleep();
        final_report();
    end
endmodule

// ### rtl/sfspd_core.sv
// serial flash suspend/resume, deep power-down and id-read command block
// assumes a mode-0 link (sample on rising, drive on falling) much slower than clk,
// and an array engine on clk that starts and finishes self-timed operations
`timescale 1ns/1ps
module sfspd_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_io0_in,
    input wire logic spi_io1_in,
    output logic spi_io0_out,
    output logic spi_io0_oe,
    output logic spi_io1_out,
    output logic spi_io1_oe,
    input wire logic op_start,
    input wire sfspd_pkg::sfspd_kind_type op_kind,
    input wire logic op_done,
    output logic array_run,
    output logic busy,
    output logic suspend_flag,
    output logic powered_down,
    output logic erase_permit,
    output logic program_permit,
    output logic status_write_permit
);
    typedef enum logic [2:0] {
        SFSPD_IDLE, SFSPD_RUN, SFSPD_SUSPENDING, SFSPD_SUSPENDED, SFSPD_RESUMING
    } sfspd_op_state_type;
    typedef enum logic [1:0] {
        SFSPD_AWAKE, SFSPD_ENTERING, SFSPD_ASLEEP, SFSPD_WAKING
    } sfspd_pd_state_type;

    // which id byte to send next
    function automatic logic [7:0] sfspd_id_byte(input logic dev_first);
        return dev_first ? sfspd_pkg::DEVICE_ID : sfspd_pkg::MANUFACTURER_ID;
    endfunction

    logic cs_s, sck_s, io0_s, io1_s;
    logic cs_d_reg, sck_d_reg;
    logic [5:0] cnt_reg, cnt_next;
    logic [7:0] op_reg, op_next;
    logic [23:0] sr_reg, sr_next;
    logic [7:0] out_sr_reg, out_sr_next;
    logic [2:0] pos_reg, pos_next;
    logic dev_sel_reg, dev_sel_next;
    logic io0_reg, io0_next, io0_oe_reg, io0_oe_next;
    logic io1_reg, io1_next, io1_oe_reg, io1_oe_next;
    logic sck_rise, sck_fall, frame_end, dual_op, out_active;
    logic cmd_suspend, cmd_resume, cmd_powerdown, cmd_release;
    logic sus_accept, res_accept;
    sfspd_op_state_type op_state_reg, op_state_next;
    sfspd_pkg::sfspd_kind_type kind_reg, kind_next;
    logic [11:0] op_timer_reg, op_timer_next;
    logic busy_reg, busy_next, sus_reg, sus_next, run_reg, run_next;
    sfspd_pd_state_type pd_state_reg, pd_state_next;
    logic [11:0] pd_timer_reg, pd_timer_next;
    logic pd_reg, pd_next, id_read_reg, id_read_next;
    logic ep_reg, ep_next, pp_reg, pp_next, wp_reg, wp_next;

    sfspd_sync #(.WIDTH(4), .RESET_VALUE(sfspd_pkg::PIN_IDLE)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({spi_cs_n, spi_sck, spi_io0_in, spi_io1_in}),
        .sync_out({cs_s, sck_s, io0_s, io1_s})
    );

    // edge detection on the synchronised link pins
    assign sck_rise = !cs_s && sck_s && !sck_d_reg;
    assign sck_fall = !cs_s && !sck_s && sck_d_reg;
    assign frame_end = cs_s && !cs_d_reg;
    assign dual_op = (op_reg == sfspd_pkg::OP_MFR_DEV_ID_DUAL);
    // id output phase; nothing is served unless awake, and ABh not while busy
    always_comb begin
        out_active = 1'b0;
        if (!cs_s && pd_state_reg == SFSPD_AWAKE) begin
            if (op_reg == sfspd_pkg::OP_RELEASE_ID)
                out_active = !busy_reg && cnt_reg >= sfspd_pkg::SINGLE_DATA_START;
            else if (op_reg == sfspd_pkg::OP_MFR_DEV_ID)
                out_active = cnt_reg >= sfspd_pkg::SINGLE_DATA_START;
            else if (dual_op)
                out_active = cnt_reg >= sfspd_pkg::DUAL_DATA_START;
        end
    end

    // commands decoded at the rising chip select, exactly eight bits clocked (release: eight or more)
    always_comb begin
        logic eight;
        eight = (cnt_reg == sfspd_pkg::OPCODE_EDGES);
        cmd_suspend = frame_end && eight && op_reg == sfspd_pkg::OP_SUSPEND;
        cmd_resume = frame_end && eight && op_reg == sfspd_pkg::OP_RESUME;
        cmd_powerdown = frame_end && eight && op_reg == sfspd_pkg::OP_POWERDOWN;
        cmd_release = frame_end && cnt_reg >= sfspd_pkg::OPCODE_EDGES
                      && op_reg == sfspd_pkg::OP_RELEASE_ID && !busy_reg;
    end

    // link shifter: opcode, address, then id bytes on falling edges
    always_comb begin
        logic [23:0] shifted;
        logic [7:0] next_byte;
        shifted = sr_reg;
        next_byte = 8'h00;
        cnt_next = cnt_reg;
        op_next = op_reg;
        sr_next = sr_reg;
        out_sr_next = out_sr_reg;
        pos_next = pos_reg;
        dev_sel_next = dev_sel_reg;
        io0_next = io0_reg;
        io1_next = io1_reg;
        io0_oe_next = io0_oe_reg && out_active;
        io1_oe_next = io1_oe_reg && out_active;
        if (cs_s) begin
            cnt_next = sfspd_pkg::EDGE_COUNT_RESET;
            pos_next = 3'h0;
            dev_sel_next = 1'b0;
            io0_oe_next = 1'b0;
            io1_oe_next = 1'b0;
            if (cs_d_reg)
                op_next = 8'h00;
        end else if (sck_rise) begin
            // address of the dual id read arrives two bits per clock
            if (dual_op && cnt_reg >= sfspd_pkg::OPCODE_EDGES)
                shifted = {sr_reg[21:0], io1_s, io0_s};
            else
                shifted = {sr_reg[22:0], io0_s};
            sr_next = shifted;
            if (cnt_reg != sfspd_pkg::EDGE_COUNT_MAX)
                cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == sfspd_pkg::OPCODE_EDGES - 6'h01)
                op_next = shifted[7:0];
            // address bit zero chooses which id comes first
            if ((op_reg == sfspd_pkg::OP_MFR_DEV_ID && cnt_reg == sfspd_pkg::SINGLE_ADDR_LAST)
                || (dual_op && cnt_reg == sfspd_pkg::DUAL_ADDR_LAST))
                dev_sel_next = shifted[0];
        end else if (sck_fall && out_active) begin
            if (pos_reg == 3'h0) begin
                next_byte = (op_reg == sfspd_pkg::OP_RELEASE_ID)
                            ? sfspd_pkg::DEVICE_ID : sfspd_id_byte(dev_sel_reg);
                if (op_reg != sfspd_pkg::OP_RELEASE_ID)
                    dev_sel_next = !dev_sel_reg;
            end else begin
                next_byte = out_sr_reg;
            end
            if (dual_op) begin
                io1_next = next_byte[7];
                io0_next = next_byte[6];
                io0_oe_next = 1'b1;
                out_sr_next = {next_byte[5:0], 2'b00};
                pos_next = pos_reg + 3'h2;
            end else begin
                io1_next = next_byte[7];
                out_sr_next = {next_byte[6:0], 1'b0};
                pos_next = pos_reg + 3'h1;
            end
            io1_oe_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
            cnt_reg <= sfspd_pkg::EDGE_COUNT_RESET;
            op_reg <= 8'h00;
            sr_reg <= 24'h000000;
            out_sr_reg <= 8'h00;
            pos_reg <= 3'h0;
            dev_sel_reg <= 1'b0;
            io0_reg <= 1'b0;
            io1_reg <= 1'b0;
            io0_oe_reg <= 1'b0;
            io1_oe_reg <= 1'b0;
        end else begin
            cs_d_reg <= cs_s;
            sck_d_reg <= sck_s;
            cnt_reg <= cnt_next;
            op_reg <= op_next;
            sr_reg <= sr_next;
            out_sr_reg <= out_sr_next;
            pos_reg <= pos_next;
            dev_sel_reg <= dev_sel_next;
            io0_reg <= io0_next;
            io1_reg <= io1_next;
            io0_oe_reg <= io0_oe_next;
            io1_oe_reg <= io1_oe_next;
        end
    end

    // array operation tracking: run, suspend, resume
    assign sus_accept = cmd_suspend && pd_state_reg == SFSPD_AWAKE && op_state_reg == SFSPD_RUN
                        && kind_reg != sfspd_pkg::SFSPD_KIND_CHIP_ERASE
                        && !sus_reg && busy_reg;
    assign res_accept = cmd_resume && pd_state_reg == SFSPD_AWAKE
                        && op_state_reg == SFSPD_SUSPENDED && sus_reg && !busy_reg;
    always_comb begin
        op_state_next = op_state_reg;
        kind_next = kind_reg;
        op_timer_next = op_timer_reg;
        unique case (op_state_reg)
            SFSPD_IDLE: begin
                if (op_start) begin
                    op_state_next = SFSPD_RUN;
                    kind_next = op_kind;
                end
            end
            SFSPD_RUN: begin
                if (sus_accept) begin
                    op_state_next = SFSPD_SUSPENDING;
                    op_timer_next = sfspd_pkg::SUSPEND_LATENCY_CYC;
                end else if (op_done) begin
                    op_state_next = SFSPD_IDLE;
                end
            end
            SFSPD_SUSPENDING: begin
                // busy falls at the end of the latency window
                if (op_timer_reg <= 12'h001)
                    op_state_next = SFSPD_SUSPENDED;
                else
                    op_timer_next = op_timer_reg - 12'h001;
            end
            SFSPD_SUSPENDED: begin
                if (res_accept)
                    op_state_next = SFSPD_RESUMING;
            end
            SFSPD_RESUMING: begin
                op_state_next = SFSPD_RUN;
            end
        endcase
        run_next = op_state_next == SFSPD_RUN;
        busy_next = op_state_next == SFSPD_RUN || op_state_next == SFSPD_SUSPENDING
                    || op_state_next == SFSPD_RESUMING;
        sus_next = op_state_next == SFSPD_SUSPENDING || op_state_next == SFSPD_SUSPENDED;
        // opcode permits while an operation stands paused
        ep_next = !(sus_next && kind_next != sfspd_pkg::SFSPD_KIND_PAGE_PROGRAM);
        pp_next = !(sus_next && kind_next == sfspd_pkg::SFSPD_KIND_PAGE_PROGRAM);
        wp_next = !sus_next;
    end

    // power loss is the reset: suspend state is cleared, so a later resume is ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_state_reg <= SFSPD_IDLE;
            kind_reg <= sfspd_pkg::SFSPD_KIND_SECTOR_ERASE;
            op_timer_reg <= sfspd_pkg::TIMER_RESET;
            run_reg <= 1'b0;
            busy_reg <= 1'b0;
            sus_reg <= 1'b0;
            ep_reg <= 1'b1;
            pp_reg <= 1'b1;
            wp_reg <= 1'b1;
        end else begin
            op_state_reg <= op_state_next;
            kind_reg <= kind_next;
            op_timer_reg <= op_timer_next;
            run_reg <= run_next;
            busy_reg <= busy_next;
            sus_reg <= sus_next;
            ep_reg <= ep_next;
            pp_reg <= pp_next;
            wp_reg <= wp_next;
        end
    end

    // deep power-down entry and release timing
    always_comb begin
        pd_state_next = pd_state_reg;
        pd_timer_next = pd_timer_reg;
        id_read_next = id_read_reg;
        unique case (pd_state_reg)
            SFSPD_AWAKE: begin
                if (cmd_powerdown) begin
                    pd_state_next = SFSPD_ENTERING;
                    pd_timer_next = sfspd_pkg::POWERDOWN_ENTRY_CYC;
                end
            end
            SFSPD_ENTERING: begin
                if (pd_timer_reg <= 12'h001)
                    pd_state_next = SFSPD_ASLEEP;
                else
                    pd_timer_next = pd_timer_reg - 12'h001;
            end
            SFSPD_ASLEEP: begin
                // only the release opcode is recognised here
                if (cmd_release) begin
                    pd_state_next = SFSPD_WAKING;
                    id_read_next = cnt_reg > sfspd_pkg::OPCODE_EDGES;
                    pd_timer_next = (cnt_reg > sfspd_pkg::OPCODE_EDGES)
                                    ? sfspd_pkg::RELEASE_WITH_ID_CYC
                                    : sfspd_pkg::RELEASE_CYC;
                end
            end
            SFSPD_WAKING: begin
                if (pd_timer_reg <= 12'h001)
                    pd_state_next = SFSPD_AWAKE;
                else
                    pd_timer_next = pd_timer_reg - 12'h001;
            end
        endcase
        pd_next = pd_state_next != SFSPD_AWAKE;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_state_reg <= SFSPD_AWAKE;
            pd_timer_reg <= sfspd_pkg::TIMER_RESET;
            pd_reg <= 1'b0;
            id_read_reg <= 1'b0;
        end else begin
            pd_state_reg <= pd_state_next;
            pd_timer_reg <= pd_timer_next;
            pd_reg <= pd_next;
            id_read_reg <= id_read_next;
        end
    end

    // outputs come straight from flops
    assign spi_io0_out = io0_reg;
    assign spi_io0_oe = io0_oe_reg;
    assign spi_io1_out = io1_reg;
    assign spi_io1_oe = io1_oe_reg;
    assign array_run = run_reg;
    assign busy = busy_reg;
    assign suspend_flag = sus_reg;
    assign powered_down = pd_reg;
    assign erase_permit = ep_reg;
    assign program_permit = pp_reg;
    assign status_write_permit = wp_reg;

    sequence s_resume_steps;
        !sus_reg && busy_reg ##1 run_reg;
    endsequence
    property p_sus_set;
        @(posedge clk) disable iff (rst) sus_accept |=> sus_reg && busy_reg;
    endproperty
    a_sus_set: assert property (p_sus_set) else $error("suspend flag not set");
    property p_sus_bound;
        @(posedge clk) disable iff (rst)
            op_state_reg == SFSPD_SUSPENDING && op_timer_reg <= 12'h001 |=> !busy_reg && sus_reg;
    endproperty
    a_sus_bound: assert property (p_sus_bound) else $error("suspend latency overrun");
    property p_sus_ignored;
        @(posedge clk) disable iff (rst)
            cmd_suspend && (sus_reg || !busy_reg || kind_reg == sfspd_pkg::SFSPD_KIND_CHIP_ERASE)
            |=> $stable(sus_reg);
    endproperty
    a_sus_ignored: assert property (p_sus_ignored) else $error("suspend not ignored");
    property p_resume;
        @(posedge clk) disable iff (rst) res_accept |=> s_resume_steps;
    endproperty
    a_resume: assert property (p_resume) else $error("resume timing wrong");
    property p_res_ignored;
        @(posedge clk) disable iff (rst) cmd_resume && (!sus_reg || busy_reg) |=> $stable(sus_reg);
    endproperty
    a_res_ignored: assert property (p_res_ignored) else $error("resume not ignored");
    property p_pd_exact;
        @(posedge clk) disable iff (rst)
            frame_end && op_reg == sfspd_pkg::OP_POWERDOWN && cnt_reg != sfspd_pkg::OPCODE_EDGES
            && pd_state_reg == SFSPD_AWAKE |=> !pd_reg;
    endproperty
    a_pd_exact: assert property (p_pd_exact) else $error("power-down on bad frame");
    property p_pd_deaf;
        @(posedge clk) disable iff (rst)
            pd_state_reg == SFSPD_ASLEEP && frame_end && op_reg != sfspd_pkg::OP_RELEASE_ID
            |=> pd_state_reg == SFSPD_ASLEEP ##1 !io1_oe_reg;
    endproperty
    a_pd_deaf: assert property (p_pd_deaf) else $error("command seen while asleep");
    property p_ab_busy;
        @(posedge clk) disable iff (rst)
            busy_reg && op_reg == sfspd_pkg::OP_RELEASE_ID |=> !io1_oe_reg;
    endproperty
    a_ab_busy: assert property (p_ab_busy) else $error("id sent while busy");
    property p_awake_after_reset;
        @(posedge clk) disable iff (rst) $fell(rst) |-> !pd_reg && !sus_reg;
    endproperty
    a_awake_after_reset: assert property (p_awake_after_reset) else $error("bad reset state");
    property p_busy_run;
        @(posedge clk) disable iff (rst) run_reg |-> busy_reg;
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy low while running");
    property p_wake_time;
        @(posedge clk) disable iff (rst)
            pd_state_reg == SFSPD_WAKING && id_read_reg
            |-> pd_timer_reg <= sfspd_pkg::RELEASE_WITH_ID_CYC;
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("release with id too long");
endmodule

// ### rtl/sfspd_sync.sv
// two-flop synchroniser bank for the serial link pins
// assumes inputs are asynchronous to clk; outputs are clk-domain levels
`timescale 1ns/1ps
module sfspd_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // one synchroniser chain per bit; first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                // reset to the pin's idle level so no false edge follows reset
                meta_reg[i] <= RESET_VALUE[i];
                sync_reg[i] <= RESET_VALUE[i];
            end else begin
                meta_reg[i] <= async_in[i];
                sync_reg[i] <= meta_reg[i];
            end
        end
    end

    assign sync_out = sync_reg;
endmodule

// ### shared/sfspd_pkg.sv
// constants for the flash suspend, power-down and id-read command block
// assumes a 125 MHz system clock that samples the serial link pins
package sfspd_pkg;
    // system clock
    localparam int CLK_PERIOD_NS = 8;
    // opcodes handled here and opcodes gated while suspended
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_POWERDOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
    localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
    localparam logic [7:0] OP_MFR_DEV_ID_DUAL = 8'h92;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    // frame bit positions, counted in link clock rising edges
    localparam logic [5:0] OPCODE_EDGES = 6'h08;
    localparam logic [5:0] SINGLE_ADDR_LAST = 6'h1F;
    localparam logic [5:0] SINGLE_DATA_START = 6'h20;
    localparam logic [5:0] DUAL_ADDR_LAST = 6'h13;
    localparam logic [5:0] DUAL_DATA_START = 6'h18;
    localparam logic [5:0] EDGE_COUNT_MAX = 6'h3F;
    // identification bytes, values are arbitrary
    localparam logic [7:0] MANUFACTURER_ID = 8'hA5;
    localparam logic [7:0] DEVICE_ID = 8'h3C;
    // times in ns and the cycle counts derived from them (longest times round down)
    localparam int SUSPEND_LATENCY_NS = 20000;
    localparam int RESUME_BUSY_NS = 200;
    localparam int POWERDOWN_ENTRY_TIME_NS = 3000;
    localparam int RELEASE_TIME_NS = 3000;
    localparam int RELEASE_WITH_ID_TIME_NS = 1800;
    localparam logic [11:0] SUSPEND_LATENCY_CYC = 12'(SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
    localparam logic [11:0] RESUME_BUSY_CYC = 12'(RESUME_BUSY_NS / CLK_PERIOD_NS);
    localparam logic [11:0] POWERDOWN_ENTRY_CYC = 12'(POWERDOWN_ENTRY_TIME_NS / CLK_PERIOD_NS);
    localparam logic [11:0] RELEASE_CYC = 12'(RELEASE_TIME_NS / CLK_PERIOD_NS);
    localparam logic [11:0] RELEASE_WITH_ID_CYC = 12'(RELEASE_WITH_ID_TIME_NS / CLK_PERIOD_NS);
    // reset values
    localparam logic [11:0] TIMER_RESET = 12'h000;
    localparam logic [5:0] EDGE_COUNT_RESET = 6'h00;
    // idle levels of {cs_n, sck, io0, io1} held by the pin synchroniser in reset
    localparam logic [3:0] PIN_IDLE = 4'h8;
    // kinds of self-timed array operation
    typedef enum logic [1:0] {
        SFSPD_KIND_SECTOR_ERASE,
        SFSPD_KIND_BLOCK_ERASE,
        SFSPD_KIND_CHIP_ERASE,
        SFSPD_KIND_PAGE_PROGRAM
    } sfspd_kind_type;
endpackage
